//--- hw/nic_bank.v
// Enable and pending bank of a 32-line nested interrupt controller, an
// AHB-Lite slave. Assumes the request lines come from outside the clock's
// domain and the core acknowledges the line it takes with a one-cycle pulse.
//
// Behaviour
// - Writing one to an enable-set bit enables that line; zero leaves it.
// - Reading enable-set returns the current enable of every line.
// - A pending enabled line is activated, chosen by its priority.
// - A request line asserting makes its line pending even when disabled.
// - A disabled line is not activated, whatever its priority, unless the core takes an offer made before its disable landed.
// - Writing one to an enable-clear bit disables that line; zero does nothing.
// - Reading enable-clear returns the same enables as enable-set.
// - Writing one to a pending-set bit makes that line pending.
// - Reading pending-set returns one per pending line.
// - Setting pending on an already pending line changes nothing.
// - Setting pending on a disabled line marks it pending, no enable.
// - Each line has a 2-bit priority, zero most urgent, three least.
// - Writing one to pending-clear removes pending, leaving active state alone.
`timescale 1ns/10ps
`include "nic_defs.vh"

module nic_bank
#(
    parameter LINES = 32
)
(
    input  wire        clk,
    input  wire        reset,
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output reg  [31:0] hrdata,
    output reg         hreadyout,
    output reg         hresp,
    input  wire [31:0] irq_lines,
    input  wire        core_ack,
    output reg         core_irq_valid,
    output reg  [4:0]  core_irq_num,
    output reg         irq_out
);
    // Synchronised request lines and edge memory.
    reg  [31:0] irq_meta;
    reg  [31:0] irq_sync;
    reg  [31:0] irq_prev;
    // Shared enable store, pending store and active state.
    reg  [31:0] enable;
    reg  [31:0] pending;
    reg  [31:0] active;
    // Event status and mask.
    reg  [`NIC_EVT_W-1:0] evt_status;
    reg  [`NIC_EVT_W-1:0] evt_mask;
    // Captured data phase.
    reg         dp_valid;
    reg         dp_write;
    reg  [15:0] dp_addr;

    // All eight priority words, flattened, for the arbiter and the read mux.
    wire [255:0] prio_words;
    wire         prio_wr;

    // Decides whether an offset falls on the priority word block.
    function is_prio;
        input [15:0] a;
        begin
            is_prio = (a >= `NIC_OFS_PRIO_BASE) && (a <= `NIC_OFS_PRIO_LAST)
                      && (a[1:0] == 2'b00);
        end
    endfunction

    // Extracts the 2-bit priority of one line from the flattened words.
    function [1:0] prio_of;
        input [255:0] w;
        input [4:0]   n;
        begin
            prio_of = w[n[4:2]*32 + n[1:0]*`NIC_PRIO_STRIDE + `NIC_PRIO_LSB +: 2];
        end
    endfunction

    assign prio_wr = dp_valid && dp_write && is_prio(dp_addr);

    // The memory's own read port is left open: the read mux takes the
    // flattened words, so that hrdata comes straight from one register.

    nic_prio_mem #(.DEPTH(8), .ADDR_W(3)) u_prio
    (
        .clk       (clk),
        .reset     (reset),
        .wr_en     (prio_wr),
        .wr_addr   (dp_addr[4:2]),
        .wr_data   (hwdata),
        .rd_addr   (haddr[4:2]),
        .rd_data   (),
        .all_words (prio_words)
    );

    // Two flip-flops on the asynchronous request lines before any logic.
    // A request therefore reaches the pending store three edges after the
    // pin rises; a pulse shorter than one clock period may be lost.
    always @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            irq_meta <= 32'h00000000;
            irq_sync <= 32'h00000000;
            irq_prev <= 32'h00000000;
        end
        else
        begin
            irq_meta <= irq_lines;
            irq_sync <= irq_meta;
            irq_prev <= irq_sync;
        end
    end

    wire [31:0] irq_rise = irq_sync & ~irq_prev;

    // Address phase capture. The slave never waits, so each transfer
    // finishes in its data phase with one cycle of latency.
    // Only whole-word transfers are taken: the registers are word-wide, and
    // a narrower access is ignored rather than applied to the wrong bits.
    always @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            dp_valid <= 1'b0;
            dp_write <= 1'b0;
            dp_addr  <= 16'h0000;
        end
        else if (hready)
        begin
            dp_valid <= hsel && htrans[1] && (hsize == 3'b010);
            dp_write <= hwrite;
            dp_addr  <= haddr[15:0];
        end
    end

    // Write strobes of the data phase. Only haddr[15:0] is decoded, so the
    // window repeats across the upper address bits; the fabric is expected
    // to raise hsel for this slave's window only.
    wire wr_eset  = dp_valid && dp_write && (dp_addr == `NIC_OFS_ENABLE_SET);
    wire wr_eclr  = dp_valid && dp_write && (dp_addr == `NIC_OFS_ENABLE_CLEAR);
    wire wr_pset  = dp_valid && dp_write && (dp_addr == `NIC_OFS_PENDING_SET);
    wire wr_pclr  = dp_valid && dp_write && (dp_addr == `NIC_OFS_PENDING_CLEAR);
    wire wr_ack   = dp_valid && dp_write && (dp_addr == `NIC_OFS_ACK);
    wire wr_evst  = dp_valid && dp_write && (dp_addr == `NIC_OFS_EVT_STATUS);
    wire wr_evmk  = dp_valid && dp_write && (dp_addr == `NIC_OFS_EVT_MASK);

    // Arbiter: lowest priority value wins, lower line number breaks ties.
    // The scan runs from the top line down and keeps a later equal value,
    // which is what gives the lower line the tie. It is one combinational
    // pass over all lines, traded for a single cycle of offer latency.
    reg        next_found;
    reg [4:0]  next_num;
    reg [1:0]  next_prio;
    integer    k;
    always @*
    begin
        next_found = 1'b0;
        next_num   = 5'd0;
        next_prio  = 2'd3;
        for (k = LINES - 1; k >= 0; k = k - 1)
        begin
            if (pending[k] && enable[k] && !active[k])
            begin
                if (!next_found || prio_of(prio_words, k[4:0]) <= next_prio)
                begin
                    next_found = 1'b1;
                    next_num   = k[4:0];
                    next_prio  = prio_of(prio_words, k[4:0]);
                end
            end
        end
    end

    // The core takes the offered line on its ack; that line becomes active
    // and leaves pending. A request edge in the same cycle wins over it.
    // The core must ack only while the offer stands; an ack with no offer
    // is ignored, so a stray pulse cannot activate a line.
    wire take = core_irq_valid && core_ack;
    wire [31:0] take_mask = take ? (32'h00000001 << core_irq_num) : 32'h00000000;
    wire [31:0] done_mask = wr_ack ? hwdata : 32'h00000000;

    // Enable store shared by both enable registers. Set and clear sit at
    // different offsets, so at most one of them acts in any cycle.
    always @(posedge clk or posedge reset)
    begin
        if (reset)
            enable <= `NIC_RST_ENABLE;
        else if (wr_eset)
            enable <= enable | hwdata;
        else if (wr_eclr)
            enable <= enable & ~hwdata;
    end

    // Pending store. Sources that set win over any clear in the same cycle.
    // Losing a clear is harmless, as software can repeat it, while losing a
    // request would drop an interrupt for good.
    always @(posedge clk or posedge reset)
    begin
        if (reset)
            pending <= `NIC_RST_PENDING;
        else
            pending <= (pending & ~(wr_pclr ? hwdata : 32'h00000000) & ~take_mask)
                       | irq_rise
                       | (wr_pset ? hwdata : 32'h00000000);
    end

    // Active state, left alone by pending-clear; software retires it.
    // An active line is never offered again until it is retired, so a
    // handler that forgets to retire its line blocks that line only.
    always @(posedge clk or posedge reset)
    begin
        if (reset)
            active <= 32'h00000000;
        else
            active <= (active & ~done_mask) | take_mask;
    end

    // Offer to the core, registered so the outputs come from flip-flops.
    // The offer drops for one cycle after a take, which keeps the core from
    // seeing the line it has just taken offered a second time.
    always @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            core_irq_valid <= 1'b0;
            core_irq_num   <= 5'd0;
        end
        else
        begin
            core_irq_valid <= next_found && !take;
            core_irq_num   <= next_num;
        end
    end

    // Event status: activation and a request edge landing on a pending line.
    // The second event tells software that two requests merged into one.
    wire [`NIC_EVT_W-1:0] evt_set;
    assign evt_set[`NIC_EVT_ACTIVATE] = take;
    assign evt_set[`NIC_EVT_OVERRUN]  = |(irq_rise & pending);

    always @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            evt_status <= {`NIC_EVT_W{1'b0}};
            evt_mask   <= {`NIC_EVT_W{1'b0}};
            irq_out    <= 1'b0;
        end
        else
        begin
            // Set wins over a write-one-to-clear in the same cycle.
            evt_status <= (evt_status & ~(wr_evst ? hwdata[`NIC_EVT_W-1:0]
                                                  : {`NIC_EVT_W{1'b0}})) | evt_set;
            if (wr_evmk)
                evt_mask <= hwdata[`NIC_EVT_W-1:0];
            irq_out <= |(evt_status & evt_mask);
        end
    end

    // Read data mux, registered at the address phase so it stands in the
    // data phase. Priority words come from the flattened copy.
    reg [31:0] next_rdata;
    always @*
    begin
        case (haddr[15:0])
            `NIC_OFS_ENABLE_SET:    next_rdata = enable;
            `NIC_OFS_ENABLE_CLEAR:  next_rdata = enable;
            `NIC_OFS_PENDING_SET:   next_rdata = pending;
            `NIC_OFS_PENDING_CLEAR: next_rdata = pending;
            `NIC_OFS_ACTIVE:        next_rdata = active;
            `NIC_OFS_EVT_STATUS:    next_rdata = {{(32-`NIC_EVT_W){1'b0}}, evt_status};
            `NIC_OFS_EVT_MASK:      next_rdata = {{(32-`NIC_EVT_W){1'b0}}, evt_mask};
            default:                next_rdata = is_prio(haddr[15:0])
                                                 ? prio_words[haddr[4:2]*32 +: 32]
                                                 : 32'h00000000;
        endcase
    end

    // The captured word stands through the whole data phase. It is taken at
    // the address phase, so a read placed directly behind a write to the
    // same register still shows the value from before that write.
    always @(posedge clk or posedge reset)
    begin
        if (reset)
            hrdata <= 32'h00000000;
        else if (hready)
            hrdata <= next_rdata;
    end

    // Bus answer: always ready and OKAY. Both are kept in flip-flops so no
    // bus output depends on logic; unmapped reads give zero.
    always @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
        else
        begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end
endmodule // nic_bank

//--- hw/nic_defs.vh
// Constants for the interrupt enable and pending bank: register offsets,
// reset values and field layouts. Included by the bank and its memory.
`ifndef NIC_DEFS_VH
`define NIC_DEFS_VH

// Byte offsets of the registers within the slave's window.
`define NIC_OFS_ENABLE_SET    16'he100
`define NIC_OFS_ENABLE_CLEAR  16'he180
`define NIC_OFS_PENDING_SET   16'he200
`define NIC_OFS_PENDING_CLEAR 16'he280
`define NIC_OFS_PRIO_BASE     16'he400
`define NIC_OFS_PRIO_LAST     16'he41c
`define NIC_OFS_ACTIVE        16'he300
`define NIC_OFS_ACK           16'he304
`define NIC_OFS_EVT_STATUS    16'he500
`define NIC_OFS_EVT_MASK      16'he504

// Reset values.
`define NIC_RST_ENABLE  32'h00000000
`define NIC_RST_PENDING 32'h00000000
`define NIC_RST_PRIO    32'h00000000

// Priority field layout inside a priority word: four lines per word.
`define NIC_PRIO_W      2
`define NIC_PRIO_LSB    6
`define NIC_PRIO_STRIDE 8

// Event status bits.
`define NIC_EVT_ACTIVATE 0
`define NIC_EVT_OVERRUN  1
`define NIC_EVT_W        2

`endif

//--- hw/nic_prio_mem.v
// Small memory for the eight priority words, four 2-bit fields per word.
// Assumes a single clock; read data come out of a register one cycle later.
`timescale 1ns/10ps
`include "nic_defs.vh"

module nic_prio_mem
#(
    parameter DEPTH  = 8,
    parameter ADDR_W = 3
)
(
    input  wire              clk,
    input  wire              reset,
    input  wire              wr_en,
    input  wire [ADDR_W-1:0] wr_addr,
    input  wire [31:0]       wr_data,
    input  wire [ADDR_W-1:0] rd_addr,
    output reg  [31:0]       rd_data,
    output wire [DEPTH*32-1:0] all_words
);
    reg [31:0] words [0:DEPTH-1];
    integer    i;

    // Only the priority fields are stored, so reserved bits always read zero.
    always @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            for (i = 0; i < DEPTH; i = i + 1)
                words[i] <= `NIC_RST_PRIO;
            rd_data <= 32'h00000000;
        end
        else
        begin
            if (wr_en)
                words[wr_addr] <= wr_data & 32'hc0c0c0c0;
            rd_data <= words[rd_addr];
        end
    end

    // The arbiter needs every field at once, so the words are also flattened.
    genvar g;
    generate
        for (g = 0; g < DEPTH; g = g + 1)
        begin : flat
            assign all_words[g*32 +: 32] = words[g];
        end
    endgenerate
endmodule // nic_prio_mem

//--- tb/nic_bank_tb.sv
// Self-checking bench for the enable and pending bank.
// Assumes the core model takes offers and the bench drives the request lines.
`timescale 1ns/10ps

module nic_bank_tb;
    logic        clk;
    logic        reset;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic [31:0] irq_lines;
    logic [3:0]  dly;
    logic        rd_dp = 1'b0;
    logic [31:0] en_m;
    logic [31:0] w;
    logic [31:0] c;
    logic [31:0] rq[$];
    logic [4:0]  aq[$];
    integer      seed;
    integer      i;
    integer      n_errors = 0;
    integer      n_compared = 0;
    wire  [31:0] hrdata;
    wire         hreadyout;
    wire         hresp;
    wire         core_ack;
    wire         core_irq_valid;
    wire  [4:0]  core_irq_num;
    wire         irq_out;

    nic_bank u_dut (.clk, .reset, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hrdata, .hreadyout, .hresp, .irq_lines, .core_ack,
        .core_irq_valid, .core_irq_num, .irq_out);
    nic_core_model u_core (.clk, .reset, .irq_valid(core_irq_valid), .dly, .ack(core_ack));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test;
        $display("Compared %0d, mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // One single transfer: address phase, then data phase, each held until hready.
    task automatic xfer(input logic wr, input logic [15:0] a, input logic [31:0] d);
        hsel   <= 1'b1;
        haddr  <= {16'h0, a};
        hwrite <= wr;
        htrans <= 2'b10;
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
    endtask

    task automatic rd(input logic [15:0] a, input logic [31:0] exp);
        rq.push_back(exp);
        xfer(1'b0, a, 32'h0);
    endtask

    // Monitor: takes the oldest note whenever a read ends or the core takes a line.
    always @(posedge clk)
    begin
        if (rd_dp)
            check(hrdata, rq.pop_front());
        rd_dp <= hsel && htrans[1] && !hwrite && hreadyout;
        if (core_ack && core_irq_valid)
            check({27'h0, core_irq_num}, {27'h0, aq.pop_front()});
    end

    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // A hang ends the run with a mismatch counted.
    initial
    begin
        #200000;
        n_errors++;
        end_of_test;
    end

    // Every transfer ends before the next begins, so a read sees all earlier writes.
    initial
    begin
        seed = 32'h16e7;
        {reset, hsel, haddr, htrans, hwrite, hwdata, irq_lines} = {1'b1, 100'h0};
        {hsize, dly, en_m} = {3'b010, 4'd3, 32'h0};
        repeat (20) @(posedge clk);
        reset <= 1'b0;
        rd(16'he100, 32'h0);
        rd(16'he200, 32'h0);
        repeat (4)
        begin
            w = $random(seed);
            c = $random(seed);
            xfer(1'b1, 16'he100, w);
            en_m = en_m | w;
            rd(16'he180, en_m);
            xfer(1'b1, 16'he180, c);
            en_m = en_m & ~c;
            rd(16'he100, en_m);
        end
        xfer(1'b1, 16'h0ff0, 32'hffffffff);
        rd(16'h0ff0, 32'h0);
        rd(16'he100, en_m);
        xfer(1'b1, 16'he180, 32'hffffffff);
        irq_lines <= 32'h20;
        repeat (6) @(posedge clk);
        xfer(1'b1, 16'he200, 32'h200);
        xfer(1'b1, 16'he200, 32'h20);
        rd(16'he200, 32'h220);
        rd(16'he100, 32'h0);
        xfer(1'b1, 16'he404, 32'h0000c000);
        xfer(1'b1, 16'he408, 32'h00004000);
        aq.push_back(5'd9);
        aq.push_back(5'd5);
        xfer(1'b1, 16'he100, 32'h220);
        for (i = 0; i < 60 && aq.size() != 0; i++)
            @(posedge clk);
        check(32'(aq.size()), 32'h0);
        rd(16'he200, 32'h0);
        check({31'h0, irq_out}, 32'h0);
        xfer(1'b1, 16'he504, 32'h1);
        repeat (3) @(posedge clk);
        check({31'h0, irq_out}, 32'h1);
        xfer(1'b1, 16'he500, 32'h1);
        repeat (3) @(posedge clk);
        check({31'h0, irq_out}, 32'h0);
        xfer(1'b1, 16'he200, 32'h8);
        xfer(1'b1, 16'he280, 32'h228);
        rd(16'he280, 32'h0);
        rd(16'he200, 32'h0);
        rd(16'he300, 32'h220);
        // Retire one active line, then let line 3 rise twice, the second time while it is pending.
        xfer(1'b1, 16'he304, 32'h20);
        rd(16'he300, 32'h200);
        irq_lines <= 32'h28;
        repeat (6) @(posedge clk);
        irq_lines <= 32'h20;
        repeat (4) @(posedge clk);
        irq_lines <= 32'h28;
        repeat (6) @(posedge clk);
        rd(16'he500, 32'h2);
        rd(16'he200, 32'h8);
        check({31'h0, irq_out}, 32'h0);
        end_of_test;
    end
endmodule // nic_bank_tb

//--- tb/nic_chk.sv
// Checker for the interrupt enable and pending bank, bound to its ports.
// Assumes zero-wait single word transfers with the offset in haddr[15:0].
`timescale 1ns/10ps

module nic_chk (
    input wire logic        clk,
    input wire logic        reset,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic        core_ack,
    input wire logic        core_irq_valid,
    input wire logic [4:0]  core_irq_num,
    input wire logic        irq_out
);
    logic        wr_ph;
    logic        rd_ph;
    logic [15:0] a_ph;
    logic [31:0] en_sh;
    logic [31:0] en_d;
    logic [31:0] msk_sh;
    logic [31:0] msk_d;

    // Shadows lag one cycle because reads and offers see state from before the write lands.
    always @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            wr_ph  <= 1'b0;
            rd_ph  <= 1'b0;
            a_ph   <= 16'h0;
            en_sh  <= 32'h0;
            en_d   <= 32'h0;
            msk_sh <= 32'h0;
            msk_d  <= 32'h0;
        end
        else
        begin
            wr_ph <= hsel && htrans[1] && hready && hwrite;
            rd_ph <= hsel && htrans[1] && hready && !hwrite;
            a_ph  <= haddr[15:0];
            en_d  <= en_sh;
            msk_d <= msk_sh;
            if (wr_ph && a_ph == 16'he100)
                en_sh <= en_sh | hwdata;
            if (wr_ph && a_ph == 16'he180)
                en_sh <= en_sh & ~hwdata;
            if (wr_ph && a_ph == 16'he504)
                msk_sh <= hwdata;
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (reset);

    chk_ready_high:
        assert property (hreadyout) else $error("slave inserted a wait state");
    chk_resp_okay:
        assert property (!hresp) else $error("slave gave an error response");
    chk_eset_read:
        assert property (rd_ph && a_ph == 16'he100 |-> hrdata == en_d)
        else $error("enable-set read differs from enables");
    chk_eclr_read:
        assert property (rd_ph && a_ph == 16'he180 |-> hrdata == en_d)
        else $error("enable-clear read differs from enables");
    chk_unmapped_zero:
        assert property (rd_ph && a_ph < 16'he000 |-> hrdata == 32'h0)
        else $error("unmapped read not zero");
    chk_valid_enabled:
        assert property (core_irq_valid |-> en_d[core_irq_num])
        else $error("disabled line offered");
    chk_ack_retire:
        assert property (core_ack && core_irq_valid |-> ##2
            (!core_irq_valid || core_irq_num != $past(core_irq_num, 2)))
        else $error("taken line offered again");
    chk_mask_quiet:
        assert property (msk_d == 32'h0 |-> !irq_out)
        else $error("interrupt output high while all masked");
endmodule // nic_chk

bind nic_bank nic_chk u_chk (.clk, .reset, .hsel, .haddr, .htrans, .hwrite, .hwdata,
    .hready, .hrdata, .hreadyout, .hresp, .core_ack, .core_irq_valid, .core_irq_num,
    .irq_out);

//--- tb/nic_core_model.sv
// Processor core model: takes each offered line after a chosen delay.
// Assumes the offer drops for one cycle after the take, so the taken line is not seen again.
`timescale 1ns/10ps

module nic_core_model (
    input  wire logic       clk,
    input  wire logic       reset,
    input  wire logic       irq_valid,
    input  wire logic [3:0] dly,
    output logic            ack
);
    logic [3:0] cnt;

    // The ack waits until cnt has counted dly cycles of offer; no stale offer follows a take.
    always @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            ack <= 1'b0;
            cnt <= 4'h0;
        end
        else if (ack)
        begin
            ack <= 1'b0;
            cnt <= 4'h0;
        end
        else if (irq_valid && cnt >= dly)
            ack <= 1'b1;
        else if (irq_valid)
            cnt <= cnt + 4'h1;
    end
endmodule // nic_core_model
